// ---- src/pwmos_pkg.sv ----
package pwmos_pkg;
   // ****************************************
   // register map
   // ****************************************
   localparam logic [7:0]  ADDR_SEGMENT   = 8'h00;
   localparam logic [7:0]  ADDR_GATE      = 8'h04;
   localparam logic [7:0]  ADDR_STATUS    = 8'h08;
   localparam logic [7:0]  ADDR_CONTROL   = 8'h0c;
   localparam int          ADDR_W         = 8;
   localparam int          REG_W          = 16;
   localparam logic [15:0] SEG_RESET      = 16'h0000;
   localparam logic [15:0] GATE_RESET     = 16'h0000;
   // ****************************************
   // field positions
   // ****************************************
   localparam int SEG_XOVER_A = 8;
   localparam int SEG_XOVER_B = 7;
   localparam int SEG_XOVER_C = 6;
   localparam int SEG_DIS_CH  = 0;
   localparam int SEG_DIS_CL  = 1;
   localparam int SEG_DIS_BH  = 2;
   localparam int SEG_DIS_BL  = 3;
   localparam int SEG_DIS_AH  = 4;
   localparam int SEG_DIS_AL  = 5;
   localparam int GATE_CHOP_HI = 8;
   localparam int GATE_CHOP_LO = 9;
   localparam int GATE_DIV_LSB = 0;
   localparam int GATE_DIV_W   = 6;
   localparam int STAT_TRIP    = 0;
   localparam int STAT_TRIPPED = 1;
   localparam int STAT_POL     = 2;
   localparam int CTRL_RUN     = 0;
   // ****************************************
   // timing
   // ****************************************
   localparam int CLK_PERIOD_NS  = 10;
   localparam int OVERLAP_NS     = 50;
   localparam int OVERLAP_CYCLES = OVERLAP_NS / CLK_PERIOD_NS;
endpackage

// ---- src/pwmos_top.sv ----
// What this block does
// - segment bits 8,7,6 cross over phases A, B, C respectively
// - crossover swaps a phase's high and low timing signals at the pins
// - segment bits 0..5 each force one output off all period
// - bits 0 and 1 disable phase C high and low
// - bit 2 B high, bit 3 B low, bit 4 A high, bit 5 A low
// - segment writes take effect only at the next cycle start
// - reset segment value zero: no crossover, all outputs enabled
// - gate bit 8 chops high outputs, bit 9 chops low outputs
// - chop frequency is clock over 2*(N+1), N gate bits 0..5
// - polarity pin low gives active-low outputs, high active-high
// - polarity pin level reads in status bit 2
// - after reset every output is off at the polarity's off level
// - low trip input resets the block and forces outputs off
// - a trip raises a trip interrupt request
// - trip input level reads in status bit 0
// - the block runs on the peripheral clock
`timescale 1ns/10ps
`default_nettype none
module pwmos_top
   import pwmos_pkg::*;
(
   input  wire logic                I_MCLK,         // peripheral clock
   input  wire logic                I_RESET,        // sync reset, active high
   input  wire logic                I_HSEL,         // ahb select
   input  wire logic [31:0]         I_HADDR,        // ahb address
   input  wire logic [1:0]          I_HTRANS,       // ahb transfer type
   input  wire logic                I_HWRITE,       // ahb write
   input  wire logic [2:0]          I_HSIZE,        // ahb size
   input  wire logic [31:0]         I_HWDATA,       // ahb write data
   input  wire logic                I_HREADY,       // ahb ready in
   output logic      [31:0]         O_HRDATA,       // ahb read data
   output logic                     O_HREADYOUT,    // ahb ready out
   output logic                     O_HRESP,        // ahb response
   input  wire logic                I_SYNC,         // cycle start pulse
   input  wire logic [2:0]          I_TU_HIGH,      // timing unit high, [2]=A
   input  wire logic [2:0]          I_TU_LOW,       // timing unit low, [2]=A
   input  wire logic                I_POLARITY,     // output polarity pin
   input  wire logic                I_TRIP_N,       // fault trip, active low
   output logic                     O_TRIP_IRQ,     // trip interrupt request
   output logic [2:0]               O_HIGH,         // high outs, [2]=A
   output logic [2:0]               O_LOW           // low outs, [2]=A
);
   import pwmos_pkg::*;

   // ****************************************
   // bus slave
   // ****************************************
   logic              ph_wr;
   logic [ADDR_W-1:0] ph_addr;
   logic [REG_W-1:0]  seg_pending;
   logic [REG_W-1:0]  seg_active;
   logic [REG_W-1:0]  gate_ctl;
   logic              running;
   logic              tripped;
   logic              trip_event;
   logic              take;

   assign take       = I_HSEL && I_HREADY && I_HTRANS[1];
   assign trip_event = !I_TRIP_N;

   always_ff @(posedge I_MCLK)
   begin
      if (I_RESET)
      begin
         ph_wr   <= 1'b0;
         ph_addr <= '0;
      end
      else
      begin
         ph_wr   <= take && I_HWRITE;
         ph_addr <= I_HADDR[ADDR_W-1:0];
      end
   end

   always_ff @(posedge I_MCLK)
   begin
      if (I_RESET)
      begin
         O_HREADYOUT <= 1'b1;
         O_HRESP     <= 1'b0;
      end
      else
      begin
         O_HREADYOUT <= 1'b1;
         O_HRESP     <= 1'b0;
      end
   end

   // read data registered one cycle ahead of the data phase
   always_ff @(posedge I_MCLK)
   begin
      if (I_RESET)
         O_HRDATA <= '0;
      else if (take && !I_HWRITE)
         unique case (I_HADDR[ADDR_W-1:0])
            ADDR_SEGMENT: O_HRDATA <= {16'h0000, seg_pending};
            ADDR_GATE:    O_HRDATA <= {16'h0000, gate_ctl};
            ADDR_STATUS:  O_HRDATA <= {29'h0, I_POLARITY, tripped, I_TRIP_N};
            ADDR_CONTROL: O_HRDATA <= {31'h0, running};
            default:      O_HRDATA <= '0;
         endcase
      else
         O_HRDATA <= '0;
   end

   // ****************************************
   // control registers
   // ****************************************
   always_ff @(posedge I_MCLK)
   begin
      if (I_RESET || trip_event)
      begin
         seg_pending <= SEG_RESET;
         gate_ctl    <= GATE_RESET;
      end
      else if (ph_wr && ph_addr == ADDR_SEGMENT)
         seg_pending <= I_HWDATA[REG_W-1:0];
      else if (ph_wr && ph_addr == ADDR_GATE)
         gate_ctl <= I_HWDATA[REG_W-1:0];
   end

   // run stays off after a trip until software sets it again
   always_ff @(posedge I_MCLK)
   begin
      if (I_RESET || trip_event)
         running <= 1'b0;
      else if (ph_wr && ph_addr == ADDR_CONTROL)
         running <= I_HWDATA[CTRL_RUN];
   end

   always_ff @(posedge I_MCLK)
   begin
      if (I_RESET)
         tripped <= 1'b0;
      else if (trip_event)
         tripped <= 1'b1;
      else if (ph_wr && ph_addr == ADDR_CONTROL && I_HWDATA[CTRL_RUN])
         tripped <= 1'b0;
   end

   always_ff @(posedge I_MCLK)
   begin
      if (I_RESET)
         O_TRIP_IRQ <= 1'b0;
      else
         O_TRIP_IRQ <= trip_event;
   end

   // segment copy applied only at cycle start
   always_ff @(posedge I_MCLK)
   begin
      if (I_RESET || trip_event)
         seg_active <= SEG_RESET;
      else if (I_SYNC)
         seg_active <= seg_pending;
   end

   // ****************************************
   // chop carrier
   // ****************************************
   logic [GATE_DIV_W-1:0] chop_cnt;
   logic [GATE_DIV_W-1:0] chop_divider;
   logic                  chop_clk;

   assign chop_divider = gate_ctl[GATE_DIV_LSB +: GATE_DIV_W];

   always_ff @(posedge I_MCLK)
   begin
      if (I_RESET || trip_event)
      begin
         chop_cnt <= '0;
         chop_clk <= 1'b0;
      end
      else if (chop_cnt >= chop_divider)
      begin
         chop_cnt <= '0;
         chop_clk <= !chop_clk;
      end
      else
         chop_cnt <= chop_cnt + 1'b1;
   end

   // ****************************************
   // output path
   // ****************************************
   logic [2:0] xover;
   logic [2:0] dis_hi;
   logic [2:0] dis_lo;
   logic [2:0] sel_hi;
   logic [2:0] sel_lo;
   logic [2:0] act_hi;
   logic [2:0] act_lo;
   logic [2:0] next_high;
   logic [2:0] next_low;

   always_comb
   begin
      xover  = {seg_active[SEG_XOVER_A], seg_active[SEG_XOVER_B],
                seg_active[SEG_XOVER_C]};
      dis_hi = {seg_active[SEG_DIS_AH], seg_active[SEG_DIS_BH],
                seg_active[SEG_DIS_CH]};
      dis_lo = {seg_active[SEG_DIS_AL], seg_active[SEG_DIS_BL],
                seg_active[SEG_DIS_CL]};
      sel_hi = (I_TU_HIGH & ~xover) | (I_TU_LOW & xover);
      sel_lo = (I_TU_LOW & ~xover) | (I_TU_HIGH & xover);
      act_hi = sel_hi & ~dis_hi;
      act_lo = sel_lo & ~dis_lo;
      if (gate_ctl[GATE_CHOP_HI])
         act_hi = act_hi & {3{chop_clk}};
      if (gate_ctl[GATE_CHOP_LO])
         act_lo = act_lo & {3{chop_clk}};
      if (!running || trip_event)
      begin
         act_hi = 3'h0;
         act_lo = 3'h0;
      end
      next_high = I_POLARITY ? act_hi : ~act_hi;
      next_low  = I_POLARITY ? act_lo : ~act_lo;
   end

   always_ff @(posedge I_MCLK)
   begin
      if (I_RESET)
      begin
         O_HIGH <= {3{!I_POLARITY}};
         O_LOW  <= {3{!I_POLARITY}};
      end
      else
      begin
         O_HIGH <= next_high;
         O_LOW  <= next_low;
      end
   end

   // ****************************************
   // chop spacing monitor
   // ****************************************
   logic                  chop_prev;
   logic [GATE_DIV_W-1:0] chop_gap;
   logic                  chop_gap_ok;

   // clocks since the last carrier toggle was seen
   always_ff @(posedge I_MCLK)
   begin
      if (I_RESET || trip_event)
      begin
         chop_prev <= 1'b0;
         chop_gap  <= '0;
      end
      else if (chop_prev != chop_clk)
      begin
         chop_prev <= chop_clk;
         chop_gap  <= '0;
      end
      else
         chop_gap <= chop_gap + 1'b1;
   end

   // a gate write spoils the interval in flight
   always_ff @(posedge I_MCLK)
   begin
      if (I_RESET || trip_event || (ph_wr && ph_addr == ADDR_GATE))
         chop_gap_ok <= 1'b0;
      else if (chop_prev != chop_clk)
         chop_gap_ok <= 1'b1;
   end

   // ****************************************
   // checks
   // ****************************************
   a_trip_off_outputs: assert property (@(posedge I_MCLK) disable iff (I_RESET)
      !I_TRIP_N |=> (O_HIGH == {3{!$past(I_POLARITY)}}) && (O_LOW == {3{!$past(I_POLARITY)}}))
      else $error("outputs not off after trip");

   a_chop_spacing: assert property (@(posedge I_MCLK) disable iff (I_RESET)
      (chop_prev != chop_clk) && chop_gap_ok |-> chop_gap == chop_divider)
      else $error("chop half period wrong");

   a_trip_irq: assert property (@(posedge I_MCLK) disable iff (I_RESET)
      !I_TRIP_N |=> O_TRIP_IRQ)
      else $error("trip irq missing");

   a_trip_clears_regs: assert property (@(posedge I_MCLK) disable iff (I_RESET)
      !I_TRIP_N |=> seg_pending == 16'h0000 && gate_ctl == 16'h0000 && !running)
      else $error("registers not cleared by trip");

   a_seg_waits_sync: assert property (@(posedge I_MCLK) disable iff (I_RESET)
      (!I_SYNC && I_TRIP_N) |=> $stable(seg_active))
      else $error("segment changed mid cycle");

   a_seg_at_sync: assert property (@(posedge I_MCLK) disable iff (I_RESET)
      (I_SYNC && I_TRIP_N) |=> seg_active == $past(seg_pending))
      else $error("segment not applied at cycle start");

   a_disable_ch: assert property (@(posedge I_MCLK) disable iff (I_RESET)
      seg_active[SEG_DIS_CH] && seg_active[SEG_DIS_CL] |=> O_HIGH[0] == !$past(I_POLARITY)
      && O_LOW[0] == !$past(I_POLARITY))
      else $error("phase c not disabled");

   a_xover_a: assert property (@(posedge I_MCLK) disable iff (I_RESET)
      running && I_TRIP_N && I_POLARITY && seg_active[SEG_XOVER_A] && !seg_active[SEG_DIS_AL]
      && !gate_ctl[GATE_CHOP_LO] |=> O_LOW[2] == $past(I_TU_HIGH[2]))
      else $error("phase a crossover wrong");

   a_stat_pol: assert property (@(posedge I_MCLK) disable iff (I_RESET)
      take && !I_HWRITE && I_HADDR[ADDR_W-1:0] == ADDR_STATUS
      |=> O_HRDATA[STAT_POL] == $past(I_POLARITY) && O_HRDATA[STAT_TRIP] == $past(I_TRIP_N))
      else $error("status bits wrong");

   a_chop_period: assert property (@(posedge I_MCLK) disable iff (I_RESET)
      $changed(chop_clk) && $stable(gate_ctl) ##1 $stable(gate_ctl) [*1] |->
      $past(chop_cnt) == 6'h00)
      else $error("chop counter not restarted");
endmodule
`default_nettype wire

// ---- sim/pwmos_gate_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module pwmos_gate_model
(
   input  wire logic [2:0] i_high,      // high side pins
   input  wire logic [2:0] i_low,       // low side pins
   input  wire logic       i_strap,     // board polarity strap
   input  wire logic       i_fault,     // fault detected
   output logic            o_polarity,  // polarity pin
   output logic            o_trip_n,    // trip line, pulled up
   output logic [2:0]      o_sw_high,   // high switch conducting
   output logic [2:0]      o_sw_low     // low switch conducting
);
   // ****************************************
   // board strap and fault comparator
   // ****************************************
   assign o_polarity = i_strap;
   assign o_trip_n   = ~i_fault;
   // ****************************************
   // gate driver input stage
   // ****************************************
   assign o_sw_high = o_polarity ? i_high : ~i_high;
   assign o_sw_low  = o_polarity ? i_low : ~i_low;
endmodule
`default_nettype wire

// ---- sim/testbench.sv ----
`timescale 1ns/10ps
`default_nettype none
module testbench;
   import pwmos_pkg::*;
   logic        I_MCLK, I_RESET, I_HSEL, I_HWRITE, I_HREADY, I_SYNC, I_POLARITY, I_TRIP_N;
   logic        O_HREADYOUT, O_HRESP, O_TRIP_IRQ, strap, fault, rsp;
   logic [31:0] I_HADDR, I_HWDATA, O_HRDATA, rd;
   logic [1:0]  I_HTRANS;
   logic [2:0]  I_HSIZE, I_TU_HIGH, I_TU_LOW, O_HIGH, O_LOW, sw_high, sw_low, eh, el;
   logic [15:0] cur_seg;
   int          error_cnt, checks, cyc, ones, edges;
   assign I_HREADY = O_HREADYOUT;
   pwmos_top pwmos_top_inst (.I_MCLK(I_MCLK), .I_RESET(I_RESET), .I_HSEL(I_HSEL),
      .I_HADDR(I_HADDR), .I_HTRANS(I_HTRANS), .I_HWRITE(I_HWRITE), .I_HSIZE(I_HSIZE),
      .I_HWDATA(I_HWDATA), .I_HREADY(I_HREADY), .O_HRDATA(O_HRDATA),
      .O_HREADYOUT(O_HREADYOUT), .O_HRESP(O_HRESP), .I_SYNC(I_SYNC), .I_TU_HIGH(I_TU_HIGH),
      .I_TU_LOW(I_TU_LOW), .I_POLARITY(I_POLARITY), .I_TRIP_N(I_TRIP_N),
      .O_TRIP_IRQ(O_TRIP_IRQ), .O_HIGH(O_HIGH), .O_LOW(O_LOW));
   pwmos_gate_model pwmos_gate_model_inst (.i_high(O_HIGH), .i_low(O_LOW), .i_strap(strap),
      .i_fault(fault), .o_polarity(I_POLARITY), .o_trip_n(I_TRIP_N), .o_sw_high(sw_high),
      .o_sw_low(sw_low));
   // ****************************************
   // clock and hang guard
   // ****************************************
   initial
   begin
      I_MCLK = 1'b0;
      forever #5 I_MCLK = ~I_MCLK;
   end
   always @(posedge I_MCLK)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         error_cnt++;
         finish_test();
      end
   end
   // ****************************************
   // tasks
   // ****************************************
   task automatic finish_test;
      if (error_cnt == 0 && checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge I_MCLK);
      I_HSEL   <= 1'b1;
      I_HADDR  <= {24'h000000, a};
      I_HTRANS <= 2'h2;
      I_HWRITE <= wr;
      @(posedge I_MCLK);
      while (I_HREADY !== 1'b1) @(posedge I_MCLK);
      I_HTRANS <= 2'h0;
      I_HWDATA <= d;
      @(posedge I_MCLK);
      while (I_HREADY !== 1'b1) @(posedge I_MCLK);
      rd = O_HRDATA;
      rsp = O_HRESP;
      I_HSEL <= 1'b0;
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
      ahb(1'b0, a, 32'h00000000);
      chk(rd, exp);
      chk({31'h0, rsp}, 32'h0);
   endtask
   task automatic settle;
      repeat (2) @(posedge I_MCLK);
      #1;
   endtask
   task automatic sync;
      @(posedge I_MCLK);
      I_SYNC <= 1'b1;
      @(posedge I_MCLK);
      I_SYNC <= 1'b0;
      settle();
   endtask
   task automatic pin_chk;
      for (int p = 0; p < 3; p++)
      begin
         eh[p] = (cur_seg[6+p] ? I_TU_LOW[p] : I_TU_HIGH[p]) & ~cur_seg[2*p];
         el[p] = (cur_seg[6+p] ? I_TU_HIGH[p] : I_TU_LOW[p]) & ~cur_seg[2*p+1];
      end
      chk({29'h0, O_HIGH}, {29'h0, I_POLARITY ? eh : ~eh});
      chk({29'h0, O_LOW}, {29'h0, I_POLARITY ? el : ~el});
   endtask
   task automatic off_chk;
      chk({26'h0, O_HIGH, O_LOW}, {26'h0, {6{~I_POLARITY}}});
   endtask
   task automatic chop_cnt(input int n, input logic lo_side);
      logic prev, cur;
      ones  = 0;
      edges = 0;
      settle();
      prev = lo_side ? sw_low[0] : sw_high[2];
      repeat (4 * (n + 1))
      begin
         @(posedge I_MCLK);
         #1;
         cur = lo_side ? sw_low[0] : sw_high[2];
         ones += cur;
         edges += (cur != prev);
         prev = cur;
      end
      chk(edges, 4);
      chk(ones, 2 * (n + 1));
      chk({31'h0, lo_side ? sw_high[2] : sw_low[0]}, 32'h0);
   endtask
   // ****************************************
   // main sequence
   // ****************************************
   initial
   begin
      {I_RESET, strap} = 2'b11;
      {I_HSEL, I_HWRITE, I_SYNC, fault} = 4'h0;
      {I_HADDR, I_HWDATA} = 64'h0;
      {I_HTRANS, I_HSIZE} = 5'h02;
      I_TU_HIGH = 3'b101;
      I_TU_LOW  = 3'b010;
      cur_seg = 16'h0000;
      repeat (6) @(posedge I_MCLK);
      I_RESET <= 1'b0;
      settle();
      off_chk();
      rdchk(ADDR_SEGMENT, {16'h0, SEG_RESET});
      rdchk(ADDR_GATE, {16'h0, GATE_RESET});
      rdchk(ADDR_STATUS, 32'h00000005);
      rdchk(8'h20, 32'h00000000);
      ahb(1'b1, ADDR_CONTROL, 32'h00000001);
      settle();
      pin_chk();
      for (int i = 0; i < 10; i++)
      begin
         ahb(1'b1, ADDR_SEGMENT, (i == 9) ? 32'h000000a7 : (32'h1 << i));
         settle();
         pin_chk();
         cur_seg = (i == 9) ? 16'h00a7 : (16'h1 << i);
         sync();
         pin_chk();
      end
      rdchk(ADDR_SEGMENT, 32'h000000a7);
      strap <= 1'b0;
      settle();
      pin_chk();
      rdchk(ADDR_STATUS, 32'h00000001);
      strap <= 1'b1;
      ahb(1'b1, ADDR_SEGMENT, 32'h00000000);
      cur_seg = 16'h0000;
      sync();
      @(posedge I_MCLK);
      I_TU_HIGH <= 3'b111;
      I_TU_LOW  <= 3'b000;
      for (int n = 0; n < 3; n++)
      begin
         ahb(1'b1, ADDR_GATE, 32'h100 | n);
         chop_cnt(n, 1'b0);
      end
      @(posedge I_MCLK);
      I_TU_HIGH <= 3'b000;
      I_TU_LOW  <= 3'b111;
      ahb(1'b1, ADDR_GATE, 32'h00000301);
      chop_cnt(1, 1'b1);
      @(posedge I_MCLK);
      fault <= 1'b1;
      @(posedge I_MCLK);
      #1;
      chk({31'h0, O_TRIP_IRQ}, 32'h1);
      settle();
      off_chk();
      ahb(1'b1, ADDR_SEGMENT, 32'h00000100);
      rdchk(ADDR_STATUS, 32'h00000006);
      fault <= 1'b0;
      settle();
      chk({31'h0, O_TRIP_IRQ}, 32'h0);
      rdchk(ADDR_SEGMENT, 32'h00000000);
      rdchk(ADDR_GATE, 32'h00000000);
      sync();
      off_chk();
      ahb(1'b1, ADDR_CONTROL, 32'h00000001);
      rdchk(ADDR_STATUS, 32'h00000005);
      settle();
      pin_chk();
      finish_test();
   end
endmodule
`default_nettype wire
